// [rtl/sld_divider.sv]
`timescale 1ns/100ps

module sld_divider (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       clr_i,
  input  wire logic                       tick_i,
  output logic                            half_o
);

  // ----------------------------------------------------------------
  // Oscillator divider, output is count MSB at 50 percent duty
  // ----------------------------------------------------------------
  logic [sld_pkg::DIV_W-1:0] cnt_r;
  logic [sld_pkg::DIV_W-1:0] cnt_nxt;

  assign cnt_nxt = clr_i  ? sld_pkg::DIV_RST :
                   tick_i ? cnt_r + 8'h01 :
                            cnt_r;
  assign half_o  = cnt_r[sld_pkg::DIV_W-1];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= sld_pkg::DIV_RST;
    else if (ce_i)
      cnt_r <= cnt_nxt;
  end

endmodule

// [rtl/sld_driver.sv]
`timescale 1ns/100ps

// Functional notes
// - Shifting on serial clock falls happens only while the active-low select is low.
// - On each serial clock fall the register moves one stage and takes the data input into stage zero.
// - The last stage is shown on the serial output, updated on serial clock rises, first in first out.
// - While load is high the latch follows the shift register, and it holds when load drops.
// - Raising select while the serial clock is low leaves the shift register untouched.
// - Toggling select while the serial clock is high causes one extra shift.
// - A latched one drives its segment in antiphase with the backplane.
// - A latched zero drives its segment in phase with the backplane.
// - With the internal oscillator the backplane is the oscillator divided by 256.
// - With an external clock each of its cycles clears the divider and the backplane runs at its rate.
// - With the oscillator pin held high the oscillator stops and the backplane and segment outputs hold static levels.

module sld_driver #(
  parameter int unsigned STATIC_CYC = sld_pkg::STATIC_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       sel_n_i,
  input  wire logic                       sclk_i,
  input  wire logic                       sdata_i,
  input  wire logic                       load_i,
  input  wire logic                       backplane_osc_pin_i,
  input  wire logic                       osc_ext_i,
  output logic                            sdata_o,
  output logic                            backplane_o,
  output logic [sld_pkg::SEG_W-1:0]       seg_o,
  output logic                            static_o
);

  // ----------------------------------------------------------------
  // Edge and mode helpers
  // ----------------------------------------------------------------
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction

  function automatic logic in_mode(input sld_pkg::sld_bp_mode_t cur, input sld_pkg::sld_bp_mode_t want);
    in_mode = (cur == want);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                           sclk_r;
  logic                           sel_n_r;
  logic                           osc_r;
  logic [sld_pkg::SEG_W-1:0]      shreg_r;
  logic [sld_pkg::SEG_W-1:0]      shreg_nxt;
  logic [sld_pkg::SEG_W-1:0]      latch_r;
  logic [sld_pkg::SEG_W-1:0]      latch_nxt;
  logic [sld_pkg::SEG_W-1:0]      seg_r;
  logic [sld_pkg::SEG_W-1:0]      seg_nxt;
  logic                           sdata_r;
  logic                           sdata_nxt;
  logic                           bp_r;
  logic                           bp_nxt;
  logic [sld_pkg::STATIC_W-1:0]   idle_r;
  logic [sld_pkg::STATIC_W-1:0]   idle_nxt;
  sld_pkg::sld_bp_mode_t          mode_r;
  sld_pkg::sld_bp_mode_t          mode_nxt;

  wire                            sclk_fall;
  wire                            sclk_rise;
  wire                            sel_edge;
  wire                            shift_norm;
  wire                            shift_extra;
  wire                            shift_en;
  wire                            osc_rise;
  wire                            osc_edge;
  wire                            osc_stuck;
  wire                            div_clr;
  wire                            div_tick;
  wire                            div_half;
  wire                            mode_int;
  wire                            mode_ext;
  wire                            mode_static;

  localparam logic [sld_pkg::STATIC_W-1:0] STATIC_LIM = sld_pkg::STATIC_W'(STATIC_CYC);

  // ----------------------------------------------------------------
  // Serial decode
  // ----------------------------------------------------------------
  assign sclk_fall   = fell(sclk_r, sclk_i);
  assign sclk_rise   = rose(sclk_r, sclk_i);
  assign sel_edge    = sel_n_r ^ sel_n_i;
  assign shift_norm  = sclk_fall & ~sel_n_i;
  assign shift_extra = sel_edge & sclk_r & sclk_i;
  assign shift_en    = shift_norm | shift_extra;

  assign shreg_nxt = shift_en ? {shreg_r[sld_pkg::SEG_W-2:0], sdata_i} : shreg_r;
  assign sdata_nxt = sclk_rise ? shreg_r[sld_pkg::SEG_W-1] : sdata_r;
  assign latch_nxt = load_i ? shreg_r : latch_r;

  // ----------------------------------------------------------------
  // Oscillator pin decode
  // ----------------------------------------------------------------
  assign osc_rise  = rose(osc_r, backplane_osc_pin_i);
  assign osc_edge  = osc_r ^ backplane_osc_pin_i;
  assign osc_stuck = (idle_r == STATIC_LIM);
  assign idle_nxt  = (osc_edge | ~backplane_osc_pin_i) ? '0 :
                     osc_stuck ? idle_r : idle_r + 20'h0_0001;
  assign mode_int    = in_mode(mode_r, sld_pkg::BP_INT);
  assign mode_ext    = in_mode(mode_r, sld_pkg::BP_EXT);
  assign mode_static = in_mode(mode_r, sld_pkg::BP_STATIC);
  assign div_clr   = mode_ext & osc_rise;
  assign div_tick  = mode_int & osc_rise;

  // ----------------------------------------------------------------
  // Backplane mode selection
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      sld_pkg::BP_INT:
      begin
        if (osc_stuck)
          mode_nxt = sld_pkg::BP_STATIC;
        else if (osc_ext_i)
          mode_nxt = sld_pkg::BP_EXT;
      end
      sld_pkg::BP_EXT:
      begin
        if (osc_stuck)
          mode_nxt = sld_pkg::BP_STATIC;
        else if (!osc_ext_i)
          mode_nxt = sld_pkg::BP_INT;
      end
      sld_pkg::BP_STATIC:
      begin
        if (!osc_stuck)
          mode_nxt = osc_ext_i ? sld_pkg::BP_EXT : sld_pkg::BP_INT;
      end
      default:
        mode_nxt = sld_pkg::BP_INT;
    endcase
  end

  // ----------------------------------------------------------------
  // Backplane and segment drive
  // ----------------------------------------------------------------
  assign bp_nxt  = mode_int ? div_half :
                   mode_ext ? osc_r :
                                                 1'b0;
  assign seg_nxt = latch_r ^ {sld_pkg::SEG_W{bp_nxt}};

  sld_divider u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .clr_i  (div_clr),
    .tick_i (div_tick),
    .half_o (div_half)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_r  <= 1'b0;
      sel_n_r <= 1'b1;
      osc_r   <= 1'b0;
      shreg_r <= sld_pkg::SHREG_RST;
      sdata_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sclk_r  <= sclk_i;
      sel_n_r <= sel_n_i;
      osc_r   <= backplane_osc_pin_i;
      shreg_r <= shreg_nxt;
      sdata_r <= sdata_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_r <= sld_pkg::LATCH_RST;
      seg_r   <= sld_pkg::LATCH_RST;
      bp_r    <= 1'b0;
      idle_r  <= '0;
      mode_r  <= sld_pkg::BP_INT;
    end
    else if (ce_i)
    begin
      latch_r <= latch_nxt;
      seg_r   <= seg_nxt;
      bp_r    <= bp_nxt;
      idle_r  <= idle_nxt;
      mode_r  <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdata_o     = sdata_r;
  assign backplane_o = bp_r;
  assign seg_o       = seg_r;
  assign static_o    = mode_static;

endmodule

// [rtl/sld_pkg.sv]
package sld_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned SEG_W      = 38;
  localparam int unsigned DIV_W      = 8;
  localparam int unsigned STATIC_W   = 20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned STATIC_TIME_US = 1000;
  localparam int unsigned STATIC_CYC     = (STATIC_TIME_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SEG_W-1:0] SHREG_RST = 38'h00_0000_0000;
  localparam logic [SEG_W-1:0] LATCH_RST = 38'h00_0000_0000;
  localparam logic [DIV_W-1:0] DIV_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Backplane source modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BP_INT    = 3'h1,
    BP_EXT    = 3'h2,
    BP_STATIC = 3'h4
  } sld_bp_mode_t;

endpackage

// [sim/sld_chk.sv]
`timescale 1ns/100ps

module sld_chk #(
  parameter int unsigned STATIC_CYC = 50
) (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      ce_i,
  input wire logic                      sclk_i,
  input wire logic                      load_i,
  input wire logic                      backplane_osc_pin_i,
  input wire logic                      osc_ext_i,
  input wire logic                      sdata_o,
  input wire logic                      backplane_o,
  input wire logic [sld_pkg::SEG_W-1:0] seg_o,
  input wire logic                      static_o
);
  // ---
  // Pin-high run length
  // ---
  int unsigned hi_cnt_r;

  always_ff @(posedge clk_i)
    if (rst_i || !backplane_osc_pin_i || !ce_i)
      hi_cnt_r <= 32'h0;
    else
      hi_cnt_r <= hi_cnt_r + 32'h1;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_val_a: assert property ($past(rst_i) |-> !sdata_o && !backplane_o && !static_o && seg_o == '0)
    else $error("outputs not cleared");
  sdo_rise_a: assert property ($changed(sdata_o) |-> $past(sclk_i) && !$past(sclk_i, 2))
    else $error("serial out moved without clock rise");
  seg_hold_a: assert property (!$stable(seg_o ^ {sld_pkg::SEG_W{backplane_o}}) |-> $past(load_i, 2))
    else $error("latch moved without load");
  seg_flip_a: assert property ($changed(backplane_o) && !$past(load_i, 2) && !static_o
    && !$past(static_o) |-> seg_o == ~$past(seg_o))
    else $error("segments not in step with backplane");
  ext_bp_a: assert property (osc_ext_i && $past(osc_ext_i, 2) && !static_o && !$past(rst_i, 2)
    |-> backplane_o == $past(backplane_osc_pin_i, 2))
    else $error("backplane not following external clock");
  static_bp_a: assert property (static_o |-> !backplane_o && $past(backplane_osc_pin_i, 2))
    else $error("static backplane wrong");
  static_entry_a: assert property (hi_cnt_r > STATIC_CYC + 3 |-> static_o)
    else $error("static mode not entered");
  static_exit_a: assert property (!backplane_osc_pin_i |-> ##2 !static_o)
    else $error("static mode not left");

  cover property (static_o);
  cover property ($rose(backplane_o) && !osc_ext_i);
  cover property ($changed(sdata_o));
endmodule

bind sld_driver sld_chk #(.STATIC_CYC(STATIC_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .sclk_i(sclk_i), .load_i(load_i), .backplane_osc_pin_i(backplane_osc_pin_i), .osc_ext_i(osc_ext_i),
  .sdata_o(sdata_o), .backplane_o(backplane_o), .seg_o(seg_o), .static_o(static_o));

// [sim/sld_host.sv]
`timescale 1ns/100ps

module sld_host #(
  parameter int unsigned HOLD = 2
) (
  input  wire logic clk_i,
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      load_o
);
  // ---
  // Serial host
  // ---
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
    load_o  = 1'b0;
  end

  // Data hold over, line shows inverse
  task automatic clk_hi();
    sclk_o  <= 1'b1;
    sdata_o <= ~sdata_o;
    repeat (HOLD) @(posedge clk_i);
  endtask

  // Clock parked low after each bit
  task automatic clk_lo(input logic b);
    sclk_o  <= 1'b0;
    sdata_o <= b;
    repeat (HOLD) @(posedge clk_i);
  endtask

  task automatic pins(input logic s, input logic l, input logic d);
    sel_n_o <= s;
    load_o  <= l;
    sdata_o <= d;
    @(posedge clk_i);
  endtask
endmodule

// [sim/test_serial_lcd_segment_driver.sv]
`timescale 1ns/100ps

module test_serial_lcd_segment_driver;
  // ---
  // Bench
  // ---
  localparam int unsigned SCYC = 50;
  logic                      clk_i, rst_i, ce_i, osc, osc_ext, sel_n, sclk, sdata, load;
  logic                      sdata_o, backplane_o, static_o;
  logic [sld_pkg::SEG_W-1:0] seg_o, prev, w;
  logic [75:0]               rows [3];
  int                        num_errors, n_tests;

  sld_host m (.clk_i(clk_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdata_o(sdata), .load_o(load));
  sld_driver #(.STATIC_CYC(SCYC)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sel_n_i(sel_n),
    .sclk_i(sclk), .sdata_i(sdata), .load_i(load), .backplane_osc_pin_i(osc), .osc_ext_i(osc_ext),
    .sdata_o(sdata_o), .backplane_o(backplane_o), .seg_o(seg_o), .static_o(static_o));

  task automatic check(input logic [sld_pkg::SEG_W-1:0] seen, input logic [sld_pkg::SEG_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [sld_pkg::SEG_W-1:0] d, input logic [sld_pkg::SEG_W-1:0] p, input int hi, input int lo);
    for (int j = hi; j >= lo; j--)
    begin
      m.clk_hi();
      check(sdata_o, p[j]);
      m.clk_lo(d[j]);
    end
  endtask

  task automatic load_chk(input logic [sld_pkg::SEG_W-1:0] exp);
    m.pins(1'b0, 1'b1, 1'b0);
    m.pins(1'b0, 1'b0, 1'b0);
    @(posedge clk_i);
    check(seg_o, exp);
  endtask

  task automatic osc_rises(input int n);
    repeat (n)
    begin
      osc <= 1'b1;
      repeat (2) @(posedge clk_i);
      osc <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    {rst_i, ce_i, osc, osc_ext, num_errors, n_tests, prev} = {2'b11, 2'b00, 64'h0, 38'h0};
    rows = '{{38'h3f_ffff_ffff, 38'h3f_ffff_ffff}, {38'h00_0000_0001, 38'h00_0000_0001},
             {38'h2a_aaaa_5555, 38'h2a_aaaa_5555}};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    m.pins(1'b0, 1'b0, 1'b0);
    foreach (rows[i])
    begin
      send(rows[i][75:38], prev, 37, 0);
      load_chk(rows[i][37:0]);
      prev = rows[i][75:38];
      $display("row %0d done", i);
    end
    m.pins(1'b1, 1'b0, 1'b0);
    send('1, {38{prev[37]}}, 37, 0);
    load_chk(prev);
    w = 38'h15_a5a5_c3c3;
    send(w, prev, 37, 19);
    m.pins(1'b1, 1'b0, 1'b0);
    m.pins(1'b0, 1'b0, 1'b0);
    send(w, prev, 18, 0);
    load_chk(w);
    m.clk_hi();
    m.pins(1'b1, 1'b0, 1'b1);
    m.clk_lo(1'b0);
    load_chk({w[36:0], 1'b1});
    m.pins(1'b0, 1'b1, 1'b0);
    m.clk_hi();
    m.clk_lo(1'b0);
    repeat (2) @(posedge clk_i);
    w = {w[35:0], 2'b10};
    check(seg_o, w);
    m.pins(1'b0, 1'b0, 1'b0);
    m.clk_hi();
    m.clk_lo(1'b1);
    repeat (2) @(posedge clk_i);
    check(seg_o, w);
    $display("serial tests done");
    osc_rises(127);
    check(backplane_o, 1'b0);
    osc_rises(1);
    check(backplane_o, 1'b1);
    check(seg_o, ~w);
    osc_rises(128);
    check(backplane_o, 1'b0);
    osc_ext <= 1'b1;
    for (int v = 1; v < 5; v++)
    begin
      osc <= v[0];
      repeat (3) @(posedge clk_i);
      check(backplane_o, v[0]);
      check(seg_o, w ^ {38{v[0]}});
    end
    osc_ext <= 1'b0;
    osc <= 1'b1;
    repeat (SCYC + 6) @(posedge clk_i);
    check(static_o, 1'b1);
    check(backplane_o, 1'b0);
    check(seg_o, w);
    osc <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(static_o, 1'b0);
    $display("backplane tests done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(seg_o, 38'h0);
    check(backplane_o, 1'b0);
    check(static_o, 1'b0);
    check(sdata_o, 1'b0);
    ce_i <= 1'b0;
    send('1, 38'h0, 37, 0);
    ce_i <= 1'b1;
    load_chk(38'h0);
    $display("reset and enable tests done");
    tally_and_finish();
  end
endmodule
